//--- rtl/gpt_pkg.sv
// Constants shared by the pin interrupt control block
package gpt_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;
  localparam int STAGES = 12;
  localparam logic [9:0] LOW_EN_ADDR = 10'h005;
  localparam logic [9:0] HIGH_EN_ADDR = 10'h006;
  localparam logic [9:0] DONE_EN_ADDR = 10'h007;
  localparam logic [9:0] LOW_ST_ADDR = 10'h008;
  localparam logic [9:0] HIGH_ST_ADDR = 10'h009;
  localparam logic [9:0] DONE_ST_ADDR = 10'h00A;
  localparam int DIR_LSB = 12;
  localparam int TRIG_LSB = 14;
  localparam int PIN_EN_BIT = 12;
  localparam int PIN_ST_BIT = 12;
  localparam logic [1:0] DIR_OFF = 2'h0;
  localparam logic [1:0] DIR_IN = 2'h1;
  localparam logic [1:0] DIR_LOW = 2'h2;
  localparam logic [1:0] DIR_HIGH = 2'h3;
  localparam logic [1:0] TRIG_LOW_LVL = 2'h0;
  localparam logic [1:0] TRIG_RISE = 2'h1;
  localparam logic [1:0] TRIG_FALL = 2'h2;
  localparam logic [1:0] TRIG_HIGH_LVL = 2'h3;
  localparam logic [15:0] REG_RESET = 16'h0000;
endpackage

//--- rtl/gpt_trig_if.sv
// Trigger mode and detector results between control and detector
`timescale 1ns/1ns
`default_nettype none
interface gpt_trig_if;
  logic [1:0] mode;
  logic evt;
  logic cond;
  modport det (input mode, output evt, output cond);
  modport ctl (output mode, input evt, input cond);
endinterface
`default_nettype wire

//--- rtl/gpt_trig_det.sv
// Pin synchroniser with level and edge trigger detection
`timescale 1ns/1ns
`default_nettype none
module gpt_trig_det (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_pin,
  gpt_trig_if.det trig
);
  logic sync_a;
  logic sync_b;
  logic prev;
  wire rise = sync_b & ~prev;
  wire fall = ~sync_b & prev;

  // Two stages before any detection
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev <= 1'b0;
    end else begin
      sync_a <= i_pin;
      sync_b <= sync_a;
      prev <= sync_b;
    end
  end

  always_comb begin
    unique case (trig.mode)
      gpt_pkg::TRIG_LOW_LVL: trig.evt = ~sync_b;
      gpt_pkg::TRIG_RISE: trig.evt = rise;
      gpt_pkg::TRIG_FALL: trig.evt = fall;
      gpt_pkg::TRIG_HIGH_LVL: trig.evt = sync_b;
    endcase
  end

  // Condition still present only for level modes
  assign trig.cond = (trig.mode == gpt_pkg::TRIG_LOW_LVL) ? ~sync_b :
                     (trig.mode == gpt_pkg::TRIG_HIGH_LVL) ? sync_b : 1'b0;
endmodule
`default_nettype wire

//--- rtl/gpt_pin_irq.sv
// Pin direction, pin trigger and shared interrupt control
`timescale 1ns/1ns
`default_nettype none
//
// Operation
// - Pin may raise the interrupt only when direction field is 01.
// - Direction field in bits 13:12 of register 0x005; 00 disables pin.
// - Direction 10 drives pin low, 11 drives pin high.
// - Pin interrupt enable bit in register 0x007 allows or blocks it.
// - Pin flag in completion status register sets when pin raises interrupt.
// - Reading pin flag clears it only if trigger condition has gone.
// - Two-bit trigger select in register 0x005 picks input trigger mode.
// - Select 00: interrupt and flag held while pin low.
// - Select 01: interrupt on pin low-to-high transition only.
// - Select 10: interrupt on pin high-to-low transition only.
// - Select 11: interrupt and flag held while pin high.
// - Interrupt active low; status read clears it and releases output, except while a level trigger condition holds.
// - Completion, touch and pin sources merged, each with enable and status.
// - Low-limit enable register with pin fields sits at 0x005.
module gpt_pin_irq (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [9:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  input wire logic [11:0] i_stage_done,
  input wire logic [11:0] i_stage_low,
  input wire logic [11:0] i_stage_high,
  input wire logic i_gpio_in,
  output logic o_gpio_out,
  output logic o_gpio_oe_n,
  output logic o_int_n
);
  logic [15:0] low_en;
  logic [15:0] high_en;
  logic [15:0] done_irq_allow_reg;
  logic [11:0] low_st;
  logic [11:0] high_st;
  logic low_chg;
  logic high_chg;
  logic [11:0] done_st;
  logic pin_flag;
  logic [11:0] done_src;

  gpt_trig_if trig ();

  gpt_trig_det u_det (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_pin(i_gpio_in),
    .trig(trig)
  );

  // Register decode
  wire wr_low_en = i_reg_wr && (i_reg_addr == gpt_pkg::LOW_EN_ADDR);
  wire wr_high_en = i_reg_wr && (i_reg_addr == gpt_pkg::HIGH_EN_ADDR);
  wire wr_done_en = i_reg_wr && (i_reg_addr == gpt_pkg::DONE_EN_ADDR);
  wire rd_low_st = i_reg_rd && (i_reg_addr == gpt_pkg::LOW_ST_ADDR);
  wire rd_high_st = i_reg_rd && (i_reg_addr == gpt_pkg::HIGH_ST_ADDR);
  wire rd_done_st = i_reg_rd && (i_reg_addr == gpt_pkg::DONE_ST_ADDR);

  // Pin fields
  wire [1:0] pin_dir = low_en[gpt_pkg::DIR_LSB +: 2];
  wire pin_is_in = (pin_dir == gpt_pkg::DIR_IN);
  wire pin_allow = done_irq_allow_reg[gpt_pkg::PIN_EN_BIT];
  assign trig.mode = low_en[gpt_pkg::TRIG_LSB +: 2];
  wire pin_evt = pin_is_in && pin_allow && trig.evt;
  wire pin_cond = pin_is_in && pin_allow && trig.cond;

  // Touch sources
  wire [11:0] next_low_st = i_stage_low & low_en[11:0];
  wire [11:0] next_high_st = i_stage_high & high_en[11:0];

  // Completion sources
  assign done_src = i_stage_done & done_irq_allow_reg[11:0];

  // Read mux
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    unique case (i_reg_addr)
      gpt_pkg::LOW_EN_ADDR: rd_mux = low_en;
      gpt_pkg::HIGH_EN_ADDR: rd_mux = high_en;
      gpt_pkg::DONE_EN_ADDR: rd_mux = done_irq_allow_reg;
      gpt_pkg::LOW_ST_ADDR: rd_mux = {4'h0, low_st};
      gpt_pkg::HIGH_ST_ADDR: rd_mux = {4'h0, high_st};
      gpt_pkg::DONE_ST_ADDR: rd_mux = {3'h0, pin_flag, done_st};
      default: rd_mux = 16'h0000;
    endcase
  end

  // Configuration registers
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      low_en <= gpt_pkg::REG_RESET;
      high_en <= gpt_pkg::REG_RESET;
      done_irq_allow_reg <= gpt_pkg::REG_RESET;
    end else begin
      if (wr_low_en) begin
        low_en <= i_reg_wdata;
      end
      if (wr_high_en) begin
        high_en <= i_reg_wdata;
      end
      if (wr_done_en) begin
        done_irq_allow_reg <= i_reg_wdata;
      end
    end
  end

  // Read data
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reg_rdata <= 16'h0000;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rd_mux;
    end
  end

  // Pin flag: set wins, read clears only once condition gone
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_flag <= 1'b0;
    end else if (pin_evt) begin
      pin_flag <= 1'b1;
    end else if (rd_done_st && !pin_cond) begin
      pin_flag <= 1'b0;
    end
  end

  // Completion status, per stage, set wins over read clear
  genvar g;
  generate
    for (g = 0; g < gpt_pkg::STAGES; g++) begin : g_done
      always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          done_st[g] <= 1'b0;
        end else if (done_src[g]) begin
          done_st[g] <= 1'b1;
        end else if (rd_done_st) begin
          done_st[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Touch status and change flags
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      low_st <= 12'h000;
      high_st <= 12'h000;
      low_chg <= 1'b0;
      high_chg <= 1'b0;
    end else begin
      low_st <= next_low_st;
      high_st <= next_high_st;
      if (next_low_st != low_st) begin
        low_chg <= 1'b1;
      end else if (rd_low_st || rd_high_st) begin
        low_chg <= 1'b0;
      end
      if (next_high_st != high_st) begin
        high_chg <= 1'b1;
      end else if (rd_low_st || rd_high_st) begin
        high_chg <= 1'b0;
      end
    end
  end

  // Shared interrupt, released on the status read edge
  wire next_pin_flag = pin_evt | (pin_flag & ~(rd_done_st & ~pin_cond));
  wire done_keep = |(done_src | (done_st & {12{~rd_done_st}}));
  wire touch_rd = rd_low_st | rd_high_st;
  wire touch_keep = (next_low_st != low_st) | (next_high_st != high_st) |
                    ((low_chg | high_chg) & ~touch_rd);
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_int_n <= 1'b1;
    end else begin
      o_int_n <= ~(next_pin_flag | done_keep | touch_keep);
    end
  end

  // Pin driver
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_gpio_out <= 1'b0;
      o_gpio_oe_n <= 1'b1;
    end else begin
      o_gpio_out <= (pin_dir == gpt_pkg::DIR_HIGH);
      o_gpio_oe_n <= ~((pin_dir == gpt_pkg::DIR_LOW) || (pin_dir == gpt_pkg::DIR_HIGH));
    end
  end
endmodule
`default_nettype wire

//--- test/gpt_pin_model.sv
// Far-side driver of the general-purpose pin
`timescale 1ns/1ns
`default_nettype none
module gpt_pin_model (
  input wire logic i_lvl,
  input wire logic i_out,
  input wire logic i_oe_n,
  output logic o_pin
);
  assign o_pin = i_oe_n ? i_lvl : i_out;
endmodule
`default_nettype wire

//--- test/gpt_pin_irq_sva.sv
// Port checker for the pin interrupt control block
`timescale 1ns/1ns
`default_nettype none
module gpt_pin_irq_sva (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [9:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic [15:0] o_reg_rdata,
  input wire logic i_gpio_in,
  input wire logic o_gpio_out,
  input wire logic o_gpio_oe_n,
  input wire logic o_int_n
);
  logic [15:0] low_sh;
  logic pin_en;
  wire logic wr_low = i_reg_wr && i_reg_addr == 10'h005;
  wire logic pin_in = low_sh[13:12] == 2'h1 && pin_en;
  wire logic [1:0] trig = low_sh[15:14];
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      low_sh <= 16'h0000;
      pin_en <= 1'b0;
    end else begin
      if (wr_low) low_sh <= i_reg_wdata;
      if (i_reg_wr && i_reg_addr == 10'h007) pin_en <= i_reg_wdata[12];
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  reset_idle_a: assert property ($rose(i_nrst) |-> o_int_n && o_gpio_oe_n)
    else $error("outputs not idle after reset");
  pin_off_a: assert property (wr_low && !i_reg_wdata[13] |-> ##2 o_gpio_oe_n)
    else $error("pin driven while off or input");
  pin_drive_a: assert property (wr_low && i_reg_wdata[13] |-> ##2
    !o_gpio_oe_n && o_gpio_out == $past(i_reg_wdata[12], 2)) else $error("pin drive wrong");
  low_readback_a: assert property (i_reg_rd && i_reg_addr == 10'h005 |=>
    o_reg_rdata == $past(low_sh)) else $error("pin config readback wrong");
  level_high_a: assert property ((pin_in && trig == 2'h3 && i_gpio_in)[*5] |-> !o_int_n)
    else $error("high level missed");
  level_low_a: assert property ((pin_in && trig == 2'h0 && !i_gpio_in)[*5] |-> !o_int_n)
    else $error("low level missed");
  edge_rise_a: assert property ((pin_in && trig == 2'h1 && !i_gpio_in)[*3] ##1
    (pin_in && trig == 2'h1 && i_gpio_in)[*5] |-> !o_int_n) else $error("rise missed");
  edge_fall_a: assert property ((pin_in && trig == 2'h2 && i_gpio_in)[*3] ##1
    (pin_in && trig == 2'h2 && !i_gpio_in)[*5] |-> !o_int_n) else $error("fall missed");
endmodule
bind gpt_pin_irq gpt_pin_irq_sva sva (.*);
`default_nettype wire

//--- test/testbench.sv
// Self-checking bench for the pin interrupt control block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic wr = 1'b0, rd = 1'b0, rd_d = 1'b0, lvl = 1'b1;
  logic pin, out, oe_n, int_n;
  logic [9:0] addr = 10'h000;
  logic [11:0] done = 12'h000;
  logic [15:0] wdata = 16'h0000, rdata;
  logic [31:0] seed = 32'h0000_7e18;
  logic [15:0] exp_q[$];
  int error_cnt = 0, checked = 0;
  always #20 i_clk = ~i_clk;
  gpt_pin_irq dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_stage_done(done),
    .i_stage_low(seed[11:0]), .i_stage_high(seed[27:16]), .i_gpio_in(pin), .o_gpio_out(out),
    .o_gpio_oe_n(oe_n), .o_int_n(int_n));
  gpt_pin_model far (.i_lvl(lvl), .i_out(out), .i_oe_n(oe_n), .o_pin(pin));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    v = v ^ (v << 5);
    return v;
  endfunction
  always @(negedge i_clk) seed = xs(seed);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic ci(input logic e);
    check({15'h0000, int_n}, {15'h0000, e});
  endtask
  task automatic reg_wr(input logic [9:0] a, input logic [15:0] d);
    @(negedge i_clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge i_clk);
    wr = 1'b0;
  endtask
  task automatic reg_rd(input logic [9:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    @(negedge i_clk);
    rd = 1'b1;
    addr = a;
    @(negedge i_clk);
    rd = 1'b0;
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge i_clk) rd_d <= rd;
  always @(negedge i_clk) if (rd_d) check(rdata, exp_q.pop_front());
  initial begin
    #100000;
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (6) @(negedge i_clk);
    i_nrst = 1'b1;
    reg_rd(10'h005, 16'h0000);
    reg_rd(10'h007, 16'h0000);
    reg_wr(10'h3ff, seed[15:0]);
    reg_rd(10'h3ff, 16'h0000);
    reg_rd(10'h008, 16'h0000);
    for (int d = 0; d < 4; d++) begin
      reg_wr(10'h005, {2'h0, d[1:0], 12'h000});
      @(negedge i_clk);
      check({15'h0000, oe_n}, {15'h0000, d < 2});
      if (d > 1) check({15'h0000, out}, {15'h0000, d[0]});
      reg_rd(10'h005, {2'h0, d[1:0], 12'h000});
    end
    reg_wr(10'h007, 16'h1000);
    for (int t = 0; t < 4; t++) begin
      reg_wr(10'h005, 16'h0000);
      lvl = ~t[0];
      repeat (6) @(negedge i_clk);
      reg_wr(10'h005, {t[1:0], 14'h1000});
      repeat (6) @(negedge i_clk);
      ci(1'b1);
      lvl = t[0];
      repeat (6) @(negedge i_clk);
      ci(1'b0);
      reg_rd(10'h00a, 16'h1000);
      repeat (2) @(negedge i_clk);
      ci(t[0] ^ t[1]);
      lvl = ~t[0];
      repeat (6) @(negedge i_clk);
      reg_rd(10'h00a, (t[0] ^ t[1]) ? 16'h0000 : 16'h1000);
      repeat (2) @(negedge i_clk);
      ci(1'b1);
    end
    reg_wr(10'h007, 16'h0000);
    reg_wr(10'h005, 16'h5000);
    lvl = 1'b1;
    repeat (6) @(negedge i_clk);
    ci(1'b1);
    reg_rd(10'h00a, 16'h0000);
    reg_wr(10'h007, 16'h0001);
    @(negedge i_clk);
    done = 12'h001;
    @(negedge i_clk);
    done = 12'h000;
    repeat (2) @(negedge i_clk);
    ci(1'b0);
    reg_rd(10'h00a, 16'h0001);
    repeat (2) @(negedge i_clk);
    ci(1'b1);
    summarize();
  end
endmodule
`default_nettype wire
